// ---- verilog/pgrs_regs.svh ----
`ifndef PGRS_REGS_SVH
`define PGRS_REGS_SVH
// ----------------------------------------------------------------------------
// Clock and timing constants
// ----------------------------------------------------------------------------
`define PGRS_CLK_KHZ 50000
`define PGRS_CLK_PERIOD_NS 20
`define PGRS_GOOD_DELAY_US 600
`define PGRS_GOOD_DROP_NS 100
`define PGRS_RELEASE_DELAY_MS 1
`define PGRS_STRAP_DELAY_US 500
`define PGRS_STRAP_DELAY_MAX_US 600
`define PGRS_GPIO_FLOAT_MAX_US 9
`define PGRS_GLITCH_NS 50
`define PGRS_RESET_MIN_US 1
`define PGRS_SLOW_OSC_START_US 150
`define PGRS_LOCK_US 1000
`define PGRS_LOCK_MIN_US 30
`define PGRS_LOCK_MAX_US 4000
`define PGRS_RESUME_LOCK_US 600
`define PGRS_RESUME_LOCK_MAX_US 1000
// Longest ignored glitch rounded down, plus one sample to accept a real low
`define PGRS_GLITCH_CYC (`PGRS_GLITCH_NS / `PGRS_CLK_PERIOD_NS + 1)
// ----------------------------------------------------------------------------
// Pin vector layout
// ----------------------------------------------------------------------------
`define PGRS_PIN_ABOVE 0
`define PGRS_PIN_RST_N 1
`define PGRS_PIN_BAT_LOW 2
`define PGRS_PIN_COIN 3
`define PGRS_PIN_EXT32K 4
`define PGRS_PIN_RING_SU 5
`define PGRS_PIN_STRAP 6
`define PGRS_STRAP_W 8
`define PGRS_PIN_W (6 + `PGRS_STRAP_W)
`define PGRS_CNT_W 16
`endif

// ---- verilog/pgrs_pkg.sv ----
`include "pgrs_regs.svh"
package pgrs_pkg;
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_OFF = 3'b001,
    LK_ADJ = 3'b010,
    LK_LOCKED = 3'b100
  } lock_state_t;

  typedef struct packed {
    logic [`PGRS_PIN_W-1:0] s1;
    logic [`PGRS_PIN_W-1:0] s2;
    logic [`PGRS_PIN_W-1:0] s3;
    logic [`PGRS_PIN_W-1:0] stb;
    logic [`PGRS_CNT_W-1:0] good_cnt;
    logic [`PGRS_CNT_W-1:0] rel_cnt;
    logic [`PGRS_CNT_W-1:0] strap_cnt;
    logic [`PGRS_CNT_W-1:0] osc_cnt;
    logic [`PGRS_CNT_W-1:0] lock_cnt;
    logic [3:0] low_cnt;
    logic rin_filt_n;
    logic good;
    logic proc_rst_n;
    logic strap_done;
    logic [`PGRS_STRAP_W-1:0] strap;
    logic osc_rdy;
    logic bat_por;
    logic resume;
    lock_state_t lk;
  } seq_state_t;

  typedef struct packed {
    logic standby_supply_good;
    logic processor_reset_n;
    logic fetch_enable;
    logic battery_por;
    logic strap_valid;
    logic [`PGRS_STRAP_W-1:0] strap_value;
    logic gpio_float;
    logic reset_out_n;
    logic slow_osc_ready_flag;
    logic ring_locked;
  } seq_out_t;
endpackage : pgrs_pkg

// ---- verilog/power_good_reset_sequencer.sv ----
`timescale 1ns/10ps
`include "pgrs_regs.svh"
// Summary of operation
// - Standby supply good rises 600 us after supply crosses the threshold.
// - Standby supply good falls within 100 ns of supply dropping.
// - Processor reset releases 1 ms after supply crosses the threshold.
// - Processor fetches instructions only while its reset is released.
// - Battery level checked only on coin insertion and supply good rising.
// - Low battery at supply good rising raises a battery power-on reset.
// - Straps sampled 500 us, at most 600 us, after processor reset release.
// - GPIOs float within 9 us of reset input going low.
// - Reset input low at least 1 us resets; lows of 50 ns or less ignored.
// - Reset output stays asserted as long as reset input is asserted.
// - Slow oscillator ready flag set once it reaches operating frequency.
// - Ring locks 0.03 to 4 ms after start-up accuracy with reference present.
// - Resuming from deepest sleep, ring relocks typically 0.6 ms, at most 1 ms.
// - Lock timing applies only with external or enabled internal 32 kHz.
module power_good_reset_sequencer #(
  parameter int GOOD_CYC = `PGRS_GOOD_DELAY_US * `PGRS_CLK_KHZ / 1000,
  parameter int RELEASE_CYC = `PGRS_RELEASE_DELAY_MS * `PGRS_CLK_KHZ,
  parameter int STRAP_CYC = `PGRS_STRAP_DELAY_US * `PGRS_CLK_KHZ / 1000,
  parameter int OSC_CYC = (`PGRS_SLOW_OSC_START_US * `PGRS_CLK_KHZ + 999) / 1000,
  parameter int LOCK_CYC = `PGRS_LOCK_US * `PGRS_CLK_KHZ / 1000,
  parameter int RESUME_CYC = `PGRS_RESUME_LOCK_US * `PGRS_CLK_KHZ / 1000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Board pins, asynchronous
  input wire logic standby_supply_above,
  input wire logic reset_in_n,
  input wire logic battery_below_th,
  input wire logic coin_cell_present,
  input wire logic ext_32k_present,
  input wire logic ring_startup_ok,
  input wire logic [`PGRS_STRAP_W-1:0] strap_pins,
  // Same-domain controls
  input wire logic slow_osc_enable,
  input wire logic resume_deep_sleep,
  // Status and reset outputs
  output pgrs_pkg::seq_out_t status
);
  localparam int CNT_MAX = (1 << `PGRS_CNT_W) - 1;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (GOOD_CYC < 1 || RELEASE_CYC <= GOOD_CYC || RELEASE_CYC > CNT_MAX) begin : g_chk_rel
    $error("release count must exceed good count and fit the counter");
  end
  if (STRAP_CYC < 1 || STRAP_CYC > `PGRS_STRAP_DELAY_MAX_US * `PGRS_CLK_KHZ / 1000) begin : g_chk_strap
    $error("strap delay out of range");
  end
  if (OSC_CYC < 1 || OSC_CYC > CNT_MAX) begin : g_chk_osc
    $error("oscillator start count out of range");
  end
  if (LOCK_CYC < 1 || LOCK_CYC > CNT_MAX || RESUME_CYC < 1 || RESUME_CYC > CNT_MAX) begin : g_chk_lock
    $error("lock counts out of range");
  end

  pgrs_pkg::seq_state_t state_reg;
  pgrs_pkg::seq_state_t state_next;
  logic [`PGRS_PIN_W-1:0] pin_vec;
  logic [`PGRS_PIN_W-1:0] stb_now;
  logic above;
  logic rin_n;
  logic ref_ok;
  logic good_rise;
  logic coin_rise;
  logic [`PGRS_CNT_W-1:0] lock_target;

  // --------------------------------------------------------------------------
  // Pin collection and agreement filter
  // --------------------------------------------------------------------------
  // Pins gathered so one three-flop chain serves them all
  assign pin_vec = {strap_pins, ring_startup_ok, ext_32k_present, coin_cell_present,
                    battery_below_th, reset_in_n, standby_supply_above};

  // A bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < `PGRS_PIN_W; i++) begin
      stb_now[i] = (state_reg.s2[i] == state_reg.s3[i]) ? state_reg.s3[i] : state_reg.stb[i];
    end
  end

  assign above = stb_now[`PGRS_PIN_ABOVE];
  assign rin_n = stb_now[`PGRS_PIN_RST_N];
  assign ref_ok = state_reg.stb[`PGRS_PIN_EXT32K] | (slow_osc_enable & state_reg.osc_rdy);
  assign lock_target = state_reg.resume ? `PGRS_CNT_W'(RESUME_CYC) : `PGRS_CNT_W'(LOCK_CYC);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.s1 = pin_vec;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.stb = stb_now;
    good_rise = 1'b0;
    coin_rise = stb_now[`PGRS_PIN_COIN] & ~state_reg.stb[`PGRS_PIN_COIN];

    // Supply good: delayed rise, fast fall on the filtered comparator
    if (!above) begin
      state_next.good_cnt = '0;
      state_next.good = 1'b0;
    end else if (!state_reg.good) begin
      if (state_reg.good_cnt == `PGRS_CNT_W'(GOOD_CYC - 1)) begin
        state_next.good = 1'b1;
        good_rise = 1'b1;
      end else begin
        state_next.good_cnt = state_reg.good_cnt + 1'b1;
      end
    end

    // Glitch filter: low must persist past the longest ignored glitch
    if (rin_n) begin
      state_next.low_cnt = '0;
      state_next.rin_filt_n = 1'b1;
    end else if (state_reg.low_cnt == 4'(`PGRS_GLITCH_CYC - 1)) begin
      state_next.rin_filt_n = 1'b0;
    end else begin
      state_next.low_cnt = state_reg.low_cnt + 1'b1;
    end

    // Processor reset held by low supply or reset input, then delayed release
    if (!above || !state_reg.rin_filt_n) begin
      state_next.rel_cnt = '0;
      state_next.proc_rst_n = 1'b0;
    end else if (!state_reg.proc_rst_n) begin
      if (state_reg.rel_cnt == `PGRS_CNT_W'(RELEASE_CYC - 1)) begin
        state_next.proc_rst_n = 1'b1;
      end else begin
        state_next.rel_cnt = state_reg.rel_cnt + 1'b1;
      end
    end

    // Strap capture a fixed time after the processor reset releases
    if (!state_reg.proc_rst_n) begin
      state_next.strap_cnt = '0;
      state_next.strap_done = 1'b0;
    end else if (!state_reg.strap_done) begin
      if (state_reg.strap_cnt == `PGRS_CNT_W'(STRAP_CYC - 1)) begin
        state_next.strap_done = 1'b1;
        state_next.strap = state_reg.stb[`PGRS_PIN_STRAP +: `PGRS_STRAP_W];
      end else begin
        state_next.strap_cnt = state_reg.strap_cnt + 1'b1;
      end
    end

    // Battery checked on exactly two events
    state_next.bat_por = (coin_rise | good_rise) & stb_now[`PGRS_PIN_BAT_LOW];

    // Slow oscillator start-up timer
    if (!slow_osc_enable) begin
      state_next.osc_cnt = '0;
      state_next.osc_rdy = 1'b0;
    end else if (!state_reg.osc_rdy) begin
      if (state_reg.osc_cnt == `PGRS_CNT_W'(OSC_CYC - 1)) begin
        state_next.osc_rdy = 1'b1;
      end else begin
        state_next.osc_cnt = state_reg.osc_cnt + 1'b1;
      end
    end

    // Ring oscillator lock sequencing
    if (resume_deep_sleep) begin
      state_next.resume = 1'b1;
    end
    unique case (state_reg.lk)
      pgrs_pkg::LK_OFF: begin
        state_next.lock_cnt = '0;
        if (state_reg.stb[`PGRS_PIN_RING_SU] && ref_ok) begin
          state_next.lk = pgrs_pkg::LK_ADJ;
        end
      end
      pgrs_pkg::LK_ADJ: begin
        if (!state_reg.stb[`PGRS_PIN_RING_SU] || !ref_ok) begin
          state_next.lk = pgrs_pkg::LK_OFF;
        end else if (state_reg.lock_cnt == lock_target - 1'b1) begin
          state_next.lk = pgrs_pkg::LK_LOCKED;
          state_next.resume = 1'b0;
        end else begin
          state_next.lock_cnt = state_reg.lock_cnt + 1'b1;
        end
      end
      pgrs_pkg::LK_LOCKED: begin
        state_next.lock_cnt = '0;
        if (resume_deep_sleep) begin
          state_next.lk = pgrs_pkg::LK_ADJ;
        end else if (!state_reg.stb[`PGRS_PIN_RING_SU]) begin
          state_next.lk = pgrs_pkg::LK_OFF;
        end
      end
      default: begin
        state_next.lk = pgrs_pkg::LK_OFF;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.s1[`PGRS_PIN_RST_N] <= 1'b1;
      state_reg.s2[`PGRS_PIN_RST_N] <= 1'b1;
      state_reg.s3[`PGRS_PIN_RST_N] <= 1'b1;
      state_reg.stb[`PGRS_PIN_RST_N] <= 1'b1;
      state_reg.rin_filt_n <= 1'b1;
      state_reg.lk <= pgrs_pkg::LK_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign status.standby_supply_good = state_reg.good;
  assign status.processor_reset_n = state_reg.proc_rst_n;
  assign status.fetch_enable = state_reg.proc_rst_n;
  assign status.battery_por = state_reg.bat_por;
  assign status.strap_valid = state_reg.strap_done;
  assign status.strap_value = state_reg.strap;
  assign status.gpio_float = ~state_reg.rin_filt_n;
  assign status.reset_out_n = state_reg.rin_filt_n;
  assign status.slow_osc_ready_flag = state_reg.osc_rdy;
  assign status.ring_locked = (state_reg.lk == pgrs_pkg::LK_LOCKED);
endmodule : power_good_reset_sequencer

// ---- verif/pgrs_board_model.sv ----
`timescale 1ns/10ps
// Board supply monitors and external reset source
module pgrs_board_model (
  // Clock
  input wire logic ref_clk,
  // Pins toward the sequencer
  output logic supply_above,
  output logic reset_n,
  output logic bat_low,
  output logic coin,
  output logic ext_32k,
  output logic ring_ok,
  output logic [7:0] straps
);
  // Power-on pin levels
  initial begin
    {supply_above, bat_low, coin, ext_32k, ring_ok} = 5'h00;
    reset_n = 1'h1;
    straps = 8'ha5;
  end
  // Pin order: supply, battery low, coin, ext ref, ring ok; settles before change
  task automatic set_pins(input logic [4:0] v);
    repeat (6) @(negedge ref_clk);
    {supply_above, bat_low, coin, ext_32k, ring_ok} = v;
  endtask : set_pins
  // Reset low pulse; under 50 cycles only when a glitch is commanded
  task automatic pulse_reset(input int cyc);
    @(negedge ref_clk);
    reset_n = 1'h0;
    repeat (cyc) @(negedge ref_clk);
    reset_n = 1'h1;
  endtask : pulse_reset
endmodule : pgrs_board_model

// ---- verif/power_good_reset_sequencer_asserts.sv ----
`timescale 1ns/10ps
// Port-level checker for the sequencer
module pgrs_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire logic standby_supply_above,
  input wire logic reset_in_n,
  input wire logic coin_cell_present,
  input wire logic ext_32k_present,
  input wire logic slow_osc_enable,
  // Outputs
  input wire pgrs_pkg::seq_out_t status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Sequencing relations between pins and status
  AST_FETCH_GATED: assert property (status.fetch_enable |-> status.processor_reset_n)
    else $error("Fetch enabled while processor reset held");
  AST_GOOD_DROP: assert property ($fell(standby_supply_above) |-> ##[1:6] !status.standby_supply_good)
    else $error("Supply good late to drop");
  AST_RELEASE_ORDER: assert property ($rose(status.processor_reset_n) |->
    status.standby_supply_good && status.reset_out_n)
    else $error("Processor reset released early");
  AST_POR_CAUSE: assert property (status.battery_por |->
    $rose(status.standby_supply_good) || coin_cell_present)
    else $error("Battery reset without an evaluation event");
  AST_FLOAT: assert property (!reset_in_n [*8] |=> status.gpio_float)
    else $error("GPIO not floated during reset");
  AST_GLITCH: assert property (reset_in_n ##1 !reset_in_n [*2] ##1 reset_in_n ##0 status.reset_out_n
    |=> status.reset_out_n [*5])
    else $error("Short reset glitch not ignored");
  AST_OUT_HELD: assert property (!reset_in_n [*4] ##0 !status.reset_out_n |=> !status.reset_out_n)
    else $error("Reset output released while input low");
  AST_PROC_HELD: assert property (!status.reset_out_n |-> ##[0:2] !status.processor_reset_n)
    else $error("Processor reset not held by reset input");
  AST_STRAP_AFTER: assert property ($rose(status.strap_valid) |-> status.processor_reset_n)
    else $error("Straps sampled before reset release");
  AST_LOCK_REF: assert property ($rose(status.ring_locked) |-> ext_32k_present || slow_osc_enable)
    else $error("Ring locked with no reference");
endmodule : pgrs_asserts
bind power_good_reset_sequencer pgrs_asserts u_asserts (.ref_clk(ref_clk), .rst(rst),
  .standby_supply_above(standby_supply_above), .reset_in_n(reset_in_n), .coin_cell_present(coin_cell_present),
  .ext_32k_present(ext_32k_present), .slow_osc_enable(slow_osc_enable), .status(status));

// ---- verif/power_good_reset_sequencer_test.sv ----
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module power_good_reset_sequencer_test;
  localparam int GOOD = 10, REL = 20, STRAP = 8, LOCK = 12, RES = 6;
  // Slow oscillator start-up of 150 us at a 20 ns clock, left at its default
  localparam int OSC = 7500;
  logic ref_clk, rst, osc_en, resume;
  logic sup, rin_n, bat, coin, ext, ring;
  logic [7:0] straps;
  pgrs_pkg::seq_out_t st;
  int err_total = 0, comparisons = 0, por_seen = 0;
  // Clock and battery reset pulse counter
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (st.battery_por === 1'h1) por_seen++;
  pgrs_board_model u_board (.ref_clk(ref_clk), .supply_above(sup), .reset_n(rin_n), .bat_low(bat),
    .coin(coin), .ext_32k(ext), .ring_ok(ring), .straps(straps));
  power_good_reset_sequencer #(.GOOD_CYC(GOOD), .RELEASE_CYC(REL), .STRAP_CYC(STRAP),
    .LOCK_CYC(LOCK), .RESUME_CYC(RES)) u_dut (.ref_clk(ref_clk), .rst(rst), .standby_supply_above(sup),
    .reset_in_n(rin_n), .battery_below_th(bat), .coin_cell_present(coin), .ext_32k_present(ext),
    .ring_startup_ok(ring), .strap_pins(straps), .slow_osc_enable(osc_en), .resume_deep_sleep(resume),
    .status(st));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = st.standby_supply_good;
      1: pick = st.processor_reset_n;
      2: pick = st.strap_valid;
      3: pick = st.gpio_float;
      4: pick = st.reset_out_n;
      5: pick = st.slow_osc_ready_flag;
      default: pick = st.ring_locked;
    endcase
  endfunction : pick
  // Counts falling edges until a status bit reaches a level
  task automatic wait_bit(input int sel, input logic v, input int lim, output int n);
    n = 0;
    while (pick(sel) !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_bit
  task automatic t_power_up;
    int n, m;
    por_seen = 0;
    u_board.set_pins(5'h18); // Supply up, battery low
    wait_bit(0, 1'h1, 100, n);
    `CHK(n >= GOOD && n <= GOOD + 6, 1'h1);
    `CHK(st.battery_por, 1'h1);
    `CHK(st.fetch_enable, 1'h0);
    wait_bit(1, 1'h1, 100, m);
    `CHK(por_seen, 1'h1);
    `CHK(n + m >= REL && n + m <= REL + 8, 1'h1);
    `CHK(st.fetch_enable, 1'h1);
    wait_bit(2, 1'h1, 100, n);
    `CHK(n >= STRAP && n <= STRAP + 4, 1'h1);
    `CHK(st.strap_value, 8'ha5);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_reset_in;
    int n;
    u_board.pulse_reset(2);
    repeat (10) @(negedge ref_clk);
    `CHK({st.reset_out_n, st.gpio_float}, 2'h2);
    fork
      u_board.pulse_reset(60);
      begin
        @(negedge ref_clk);
        wait_bit(3, 1'h1, 450, n);
        `CHK(n >= 3 && n <= 450, 1'h1);
        repeat (40) @(negedge ref_clk);
        `CHK(st.reset_out_n, 1'h0);
        `CHK(st.processor_reset_n, 1'h0);
      end
    join
    wait_bit(1, 1'h1, 100, n);
    `CHK(n >= REL && n <= REL + 10, 1'h1);
    $display("test reset_in done");
  endtask : t_reset_in
  task automatic t_battery;
    int n;
    por_seen = 0;
    u_board.set_pins(5'h10); // Battery recovers
    u_board.set_pins(5'h18); // Battery low again
    u_board.set_pins(5'h14); // Coin inserted, battery fine
    repeat (8) @(negedge ref_clk);
    `CHK(por_seen, 1'h0);
    u_board.set_pins(5'h04); // Supply drops
    wait_bit(0, 1'h0, 20, n);
    `CHK(n <= 5, 1'h1);
    u_board.set_pins(5'h14);
    wait_bit(1, 1'h1, 100, n);
    `CHK(por_seen, 1'h0);
    // Coin removed with battery low, then inserted again
    u_board.set_pins(5'h18);
    u_board.set_pins(5'h1c);
    repeat (8) @(negedge ref_clk);
    `CHK(por_seen, 1'h1);
    $display("test battery done");
  endtask : t_battery
  task automatic t_osc_lock;
    int n;
    u_board.set_pins(5'h15); // Ring ready, no reference
    repeat (LOCK + 10) @(negedge ref_clk);
    `CHK(st.ring_locked, 1'h0);
    osc_en = 1'h1;
    wait_bit(5, 1'h1, OSC + 10, n);
    `CHK(n >= OSC && n <= OSC + 3, 1'h1);
    wait_bit(6, 1'h1, 100, n);
    `CHK(n >= LOCK && n <= LOCK + 4, 1'h1);
    u_board.set_pins(5'h17); // External reference joins
    repeat (6) @(negedge ref_clk); // Reference settles before the internal one leaves
    osc_en = 1'h0;
    resume = 1'h1;
    @(negedge ref_clk);
    resume = 1'h0;
    wait_bit(6, 1'h0, 4, n);
    `CHK(st.ring_locked, 1'h0);
    wait_bit(6, 1'h1, 50, n);
    `CHK(n >= RES - 2 && n <= RES + 2, 1'h1);
    $display("test osc_lock done");
  endtask : t_osc_lock
  task automatic report_and_stop;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    ref_clk = 1'h0;
    rst = 1'h1;
    osc_en = 1'h0;
    resume = 1'h0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    t_power_up;
    t_reset_in;
    t_battery;
    t_osc_lock;
    report_and_stop;
  end
  // Watchdog, about two and a half times the expected run
  initial begin
    #400000;
    err_total++;
    report_and_stop;
  end
endmodule : power_good_reset_sequencer_test
